/* design/i2c_serial_nvram_slave.sv */
// two-wire serial memory slave: protocol engine, address latch, write protect
module i2c_serial_nvram_slave #(
    parameter logic [3:0] DEVICE_TYPE = 4'h6 // arbitrary device-type code
)(
    input  wire logic                        clk,
    input  wire logic                        nrst,
    input  wire logic                        scl,
    input  wire logic                        sda_in,
    output logic                             sda_out,
    output logic                             sda_oe,
    input  wire logic [nvram_pkg::SEL_W-1:0] select_address_pins,
    input  wire logic                        write_protect
);
    import nvram_pkg::*;

    state_t              state;
    state_t              next_state;
    logic [3:0]          cnt;
    logic [DATA_W-1:0]   rx;
    logic [DATA_W-1:0]   tx;
    logic [ADDR_W-1:0]   addr;
    logic [HI_W-1:0]     addr_hi;
    logic                ack_drive;
    logic                scl_q;
    logic                sda_q;
    logic                mem_we;
    logic [ADDR_W-1:0]   mem_waddr;
    logic [DATA_W-1:0]   mem_wdata;
    logic [DATA_W-1:0]   rd_data;

    wire                 scl_rise;
    wire                 scl_fall;
    wire                 start_seen;
    wire                 stop_seen;
    wire                 rx_state;
    wire [DATA_W-1:0]    byte_in;
    wire                 byte_done;
    wire                 ack_rise;
    wire                 ack_end;
    wire                 dev_match;
    wire                 write_go;
    wire                 write_block;
    wire                 read_done;
    wire                 ack_next;
    wire                 tx_shift;
    wire                 master_nack;
    wire                 idle_bus;

    // bus events; start and stop are sda edges while scl stays high
    assign scl_rise   = scl && !scl_q;
    assign scl_fall   = !scl && scl_q;
    assign start_seen = scl && scl_q && sda_q && !sda_in;
    assign stop_seen  = scl && scl_q && !sda_q && sda_in;
    assign idle_bus   = start_seen || stop_seen || (state == ST_IDLE);

    // byte assembly, most significant bit first
    assign rx_state  = (state == ST_DEVICE) || (state == ST_ADDR_HI)
                    || (state == ST_ADDR_LO) || (state == ST_WRITE);
    assign byte_in   = {rx[NEXT_POS:0], sda_in};
    assign byte_done = scl_rise && (cnt == LAST_BIT) && !idle_bus;
    assign ack_rise  = scl_rise && (cnt == ACK_BIT) && !idle_bus;
    assign ack_end   = scl_fall && (cnt == ACK_END) && !idle_bus;

    // byte decode
    assign dev_match   = (byte_in[TYPE_HI:TYPE_LO] == DEVICE_TYPE)
                      && (byte_in[SEL_HI:SEL_LO] == select_address_pins);
    assign write_go    = byte_done && (state == ST_WRITE) && !write_protect;
    assign write_block = byte_done && (state == ST_WRITE) && write_protect;
    assign read_done   = byte_done && (state == ST_READ);
    assign master_nack = ack_rise && (state == ST_READ) && !ack_drive && sda_in;
    assign tx_shift    = scl_fall && (state == ST_READ) && (cnt != CNT_ZERO)
                      && (cnt < ACK_BIT) && !idle_bus;

    // device acknowledges addressing at once, data only if unprotected
    assign ack_next = ((state == ST_DEVICE) && dev_match)
                   || (state == ST_ADDR_HI) || (state == ST_ADDR_LO)
                   || ((state == ST_WRITE) && !write_protect);

    // transfer sequence, decided when a byte completes
    always_comb begin
        next_state = state;
        case (state)
            ST_DEVICE: begin
                if (!dev_match) begin
                    next_state = ST_IDLE;
                end else if (byte_in[RW_POS] == RW_READ) begin
                    next_state = ST_READ;
                end else begin
                    next_state = ST_ADDR_HI;
                end
            end
            ST_ADDR_HI: next_state = ST_ADDR_LO;
            ST_ADDR_LO: next_state = ST_WRITE;
            ST_WRITE: begin
                if (write_protect) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = state;
        endcase
    end

    // state register; start re-arms from any point, stop parks the engine
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state <= ST_IDLE;
        end else if (start_seen) begin
            state <= ST_DEVICE;
        end else if (stop_seen || master_nack) begin
            state <= ST_IDLE;
        end else if (byte_done) begin
            state <= next_state;
        end
    end

    // bit counter: 0..7 data bits, 8 acknowledge clock, 9 after it
    always_ff @(posedge clk) begin
        if (!nrst || idle_bus || ack_end) begin
            cnt <= CNT_ZERO;
        end else if (scl_rise) begin
            cnt <= 4'(cnt + 1'b1);
        end
    end

    // receive shifter
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rx <= '0;
        end else if (scl_rise && rx_state && (cnt < ACK_BIT)) begin
            rx <= byte_in;
        end
    end

    // acknowledge decision held until the acknowledge clock ends
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ack_drive <= 1'b0;
        end else if (byte_done) begin
            ack_drive <= ack_next;
        end
    end

    // high address bits kept until the low byte arrives
    always_ff @(posedge clk) begin
        if (!nrst) begin
            addr_hi <= '0;
        end else if (byte_done && (state == ST_ADDR_HI)) begin
            addr_hi <= byte_in[HI_W-1:0];
        end
    end

    // address latch: loaded from the address bytes, stepped before the ack of each read byte or unprotected data byte
    always_ff @(posedge clk) begin
        if (!nrst) begin
            addr <= ADDR_FIRST;
        end else if (byte_done && (state == ST_ADDR_LO)) begin
            addr <= {addr_hi, byte_in};
        end else if (write_go || read_done) begin
            addr <= next_addr(addr);
        end
    end

    // array write issued right after the eighth bit, no page buffer
    always_ff @(posedge clk) begin
        if (!nrst) begin
            mem_we    <= 1'b0;
            mem_waddr <= ADDR_FIRST;
            mem_wdata <= '0;
        end else begin
            mem_we    <= write_go;
            mem_waddr <= addr;
            mem_wdata <= byte_in;
        end
    end

    // transmit shifter loaded at the end of each acknowledge clock
    always_ff @(posedge clk) begin
        if (!nrst) begin
            tx <= '0;
        end else if (ack_end) begin
            tx <= rd_data;
        end else if (tx_shift) begin
            tx <= tx << 1;
        end
    end

    // open-drain data pin: enable pulls low for ack and zero read bits
    always_ff @(posedge clk) begin
        if (!nrst || idle_bus) begin
            sda_oe <= 1'b0;
        end else if (scl_fall && (cnt == ACK_BIT)) begin
            sda_oe <= ack_drive;
        end else if (ack_end) begin
            sda_oe <= (state == ST_READ) && !rd_data[MSB_POS];
        end else if (tx_shift) begin
            sda_oe <= !tx[NEXT_POS];
        end
    end

    // line history for event detection; the pin level itself is constant
    always_ff @(posedge clk) begin
        if (!nrst) begin
            scl_q   <= LINE_IDLE;
            sda_q   <= LINE_IDLE;
            sda_out <= DRIVE_LEVEL;
        end else begin
            scl_q   <= scl;
            sda_q   <= sda_in;
            sda_out <= DRIVE_LEVEL;
        end
    end

    nvram_array #(
        .ADDR_W (ADDR_W),
        .DATA_W (DATA_W)
    ) nvram_array_inst (
        .clk   (clk),
        .we    (mem_we),
        .waddr (mem_waddr),
        .wdata (mem_wdata),
        .raddr (addr),
        .rdata (rd_data)
    );

    // checks on the protocol engine
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    data_ack_a: assert property (write_go |=> ack_drive && state == ST_WRITE)
        else $error("unprotected data byte not acknowledged");
    write_wrap_a: assert property (write_go && addr == ADDR_LAST |=> addr == ADDR_FIRST)
        else $error("write address did not wrap");
    dev_ack_a: assert property (byte_done && state == ST_DEVICE && dev_match |=> ack_drive)
        else $error("matching slave address not acknowledged");
    array_write_a: assert property (mem_we |-> $past(write_go) && mem_waddr == $past(addr))
        else $error("array write without a completed byte");
    abort_nowrite_a: assert property (start_seen || stop_seen |=> !mem_we)
        else $error("array written after abort");
    protect_nack_a: assert property (write_block |=> !ack_drive && state == ST_IDLE)
        else $error("protected byte acknowledged");
    protect_hold_a: assert property (write_block |=> addr == $past(addr))
        else $error("address moved on protected write");
    read_first_a: assert property (ack_end && state == ST_READ |=> sda_oe == !$past(rd_data[MSB_POS]))
        else $error("read data not driven from current address");
    read_step_a: assert property (read_done |=> addr == next_addr($past(addr)))
        else $error("address not stepped after read byte");
    read_more_a: assert property (ack_rise && state == ST_READ && !ack_drive && !sda_in
        && !start_seen && !stop_seen |=> state == ST_READ)
        else $error("master acknowledge did not continue read");
    read_wrap_a: assert property (read_done && addr == ADDR_LAST |=> addr == ADDR_FIRST)
        else $error("read address did not wrap");
    restart_keep_a: assert property (start_seen && state == ST_WRITE |=> state == ST_DEVICE
        && addr == $past(addr))
        else $error("repeated start lost the loaded address");
    addr_load_a: assert property (byte_done && state == ST_ADDR_LO |=> addr == {addr_hi, $past(byte_in)})
        else $error("address bytes not loaded");

    // pin behaviour around the acknowledge clock
    ack_pin_a: assert property (scl_fall && cnt == ACK_BIT && !idle_bus |=> sda_oe == $past(ack_drive))
        else $error("acknowledge drive does not follow the decision");
    ack_release_a: assert property (ack_end && state != ST_READ |=> !sda_oe)
        else $error("data line held after a received byte");
    read_turn_a: assert property (read_done |=> !ack_drive && state == ST_READ)
        else $error("device kept the acknowledge of a read byte");
    device_nack_a: assert property (byte_done && state == ST_DEVICE && !dev_match
        |=> !ack_drive && state == ST_IDLE)
        else $error("foreign slave byte answered");

    // slave byte decode and bus conditions
    dev_read_a: assert property (byte_done && state == ST_DEVICE && dev_match
        && byte_in[RW_POS] == RW_READ |=> state == ST_READ)
        else $error("read slave byte did not start a read");
    dev_write_a: assert property (byte_done && state == ST_DEVICE && dev_match
        && byte_in[RW_POS] != RW_READ |=> state == ST_ADDR_HI)
        else $error("write slave byte did not expect an address");
    start_arm_a: assert property (start_seen |=> state == ST_DEVICE && cnt == CNT_ZERO && !sda_oe)
        else $error("start did not re-arm the engine");
    stop_idle_a: assert property (stop_seen |=> state == ST_IDLE && !sda_oe)
        else $error("stop did not park the engine");

    // write path
    write_step_a: assert property (write_go |=> addr == next_addr($past(addr)) && cnt == ACK_BIT)
        else $error("write address not stepped before the acknowledge");
    write_data_a: assert property (write_go |=> mem_we && mem_wdata == $past(byte_in))
        else $error("array write lost the received byte");
    protect_nowrite_a: assert property (write_block |=> !mem_we)
        else $error("protected byte written");
    addr_hi_a: assert property (byte_done && state == ST_ADDR_HI
        |=> addr_hi == $past(byte_in[HI_W-1:0]) && state == ST_ADDR_LO)
        else $error("high address byte not kept");

    // read path and idle line
    read_nack_a: assert property (master_nack |=> state == ST_IDLE)
        else $error("master no-acknowledge did not end the read");
    tx_bit_a: assert property (tx_shift |=> sda_oe == !$past(tx[NEXT_POS]))
        else $error("read bit not driven in order");
    idle_quiet_a: assert property (state == ST_IDLE |=> !sda_oe)
        else $error("data line driven while idle");

    // scenarios worth reaching: write, sequential read, protection, selective read, read end
    write_cov: cover property (write_go ##[1:1000] ack_end);
    read_cov: cover property (read_done ##[1:1000] ack_end ##[1:1000] read_done);
    protect_cov: cover property (write_block);
    select_cov: cover property (start_seen && state == ST_WRITE ##[1:1000] state == ST_READ);
    nack_cov: cover property (master_nack ##[1:1000] start_seen);
endmodule

/* design/nvram_pkg.sv */
// constants, states and helpers shared by the serial memory slave
// Notes on behaviour
// - write opens: slave byte, address bytes, data
// - unprotected data bytes always acknowledged, unlimited count
// - write address wraps 1FFFh to 0000h
// - no busy time; addressing always acknowledged
// - array written after eighth bit, before acknowledge
// - start or stop before eighth bit aborts
// - protect high: data bytes not acknowledged
// - protected attempt leaves address counter unchanged
// - protect low enables writes; default low
// - read byte drives data from current address
// - read address follows previous access
// - address increments after every read byte
// - master acknowledge requests next sequential byte
// - read address wraps 1FFFh to 0000h
// - repeated start after address keeps new address
// - slave byte: type, three select bits, direction
// - two address bytes, high first, 13 bits
// - address increments just before acknowledge bit
// - all bytes shifted most significant bit first
package nvram_pkg;
    localparam int              ADDR_W      = 13;
    localparam int              DATA_W      = 8;
    localparam int              SEL_W       = 3;
    localparam int              HI_W        = ADDR_W - DATA_W;
    localparam logic [12:0]     ADDR_FIRST  = 13'h0000;
    localparam logic [12:0]     ADDR_LAST   = 13'h1FFF;
    localparam logic [3:0]      CNT_ZERO    = 4'h0;
    localparam logic [3:0]      LAST_BIT    = 4'h7;
    localparam logic [3:0]      ACK_BIT     = 4'h8;
    localparam logic [3:0]      ACK_END     = 4'h9;
    localparam int              TYPE_HI     = 7;
    localparam int              TYPE_LO     = 4;
    localparam int              SEL_HI      = 3;
    localparam int              SEL_LO      = 1;
    localparam int              RW_POS      = 0;
    localparam int              MSB_POS     = 7;
    localparam int              NEXT_POS    = 6;
    localparam logic            RW_READ     = 1'b1;
    localparam logic            LINE_IDLE   = 1'b1;
    localparam logic            DRIVE_LEVEL = 1'b0;

    typedef enum logic [5:0] {
        ST_IDLE    = 6'b000001,
        ST_DEVICE  = 6'b000010,
        ST_ADDR_HI = 6'b000100,
        ST_ADDR_LO = 6'b001000,
        ST_WRITE   = 6'b010000,
        ST_READ    = 6'b100000
    } state_t;

    // next sequential location, rolling over at the top
    function automatic logic [ADDR_W-1:0] next_addr(input logic [ADDR_W-1:0] a);
        return (a == ADDR_LAST) ? ADDR_FIRST : ADDR_W'(a + 1'b1);
    endfunction
endpackage

/* design/nvram_array.sv */
// byte-wide storage array with registered read data
module nvram_array #(
    parameter int ADDR_W = 13,
    parameter int DATA_W = 8
)(
    input  wire logic              clk,
    input  wire logic              we,
    input  wire logic [ADDR_W-1:0] waddr,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic [ADDR_W-1:0] raddr,
    output logic      [DATA_W-1:0] rdata
);
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

    // one write port, read data follows the read address by one clock
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule

/* sim/bus_master.sv */
// two-wire bus master model: start, stop and byte transfers on scl and sda
module bus_master (
    input  wire logic clk,
    output logic      scl,
    output logic      sda_low,
    input  wire logic sda
);
    timeunit 1ns;
    timeprecision 1ps;

    // bus idle: scl stands high, sda released to its pull-up
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // wait whole clock cycles, then step just off the edge
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask

    // start or repeated start, scl left low
    task automatic start_cond();
        sda_low = 1'b0;
        wait_clk(4);
        scl = 1'b1;
        wait_clk(4);
        sda_low = 1'b1;
        wait_clk(4);
        scl = 1'b0;
        wait_clk(2);
    endtask

    // stop: sda rises while scl high, bus then idle
    task automatic stop_cond();
        sda_low = 1'b1;
        wait_clk(4);
        scl = 1'b1;
        wait_clk(4);
        sda_low = 1'b0;
        wait_clk(4);
    endtask

    // one bit clock: drive b (1 releases), return the level seen mid-high
    task automatic bit_clk(input logic b, output logic s);
        wait_clk(1);
        sda_low = ~b;
        wait_clk(4);
        scl = 1'b1;
        wait_clk(2);
        s = sda;
        wait_clk(2);
        scl = 1'b0;
    endtask

    // send a byte, most significant bit first, and read the slave's answer
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_clk(d[i], s);
        bit_clk(1'b1, s);
        ack = ~s;
    endtask

    // receive a byte; ack asks for the next one, otherwise nack
    task automatic rd_byte(input logic ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_clk(1'b1, s);
            d[i] = s;
        end
        bit_clk(~ack, s);
    endtask
endmodule

/* sim/tb.sv */
// self-checking bench for the serial memory slave
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import nvram_pkg::*;
    localparam logic [3:0] DEV = 4'h6; // arbitrary device-type code
    localparam logic [2:0] SEL = 3'h5;
    logic       clk, nrst, scl, sda_low, sda_out, sda_oe, write_protect, sda;
    logic [2:0] select_address_pins;
    int         err_total, checked, cycles;

    // open-drain wire with pull-up
    assign sda = (sda_oe ? sda_out : 1'b1) & ~sda_low;
    assign select_address_pins = SEL;

    i2c_serial_nvram_slave #(.DEVICE_TYPE(DEV)) i2c_serial_nvram_slave_inst (
        .clk(clk), .nrst(nrst), .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .select_address_pins(select_address_pins), .write_protect(write_protect));
    bus_master bus_master_inst (.clk(clk), .scl(scl), .sda_low(sda_low), .sda(sda));

    // compare and count
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // start, write-addressed slave byte and both address bytes
    task automatic set_addr(input logic [7:0] hi, input logic [7:0] lo);
        logic a;
        bus_master_inst.start_cond();
        bus_master_inst.wr_byte({DEV, SEL, 1'b0}, a);
        chk("slave ack", 8'h01, {7'h00, a});
        bus_master_inst.wr_byte(hi, a);
        chk("addr hi ack", 8'h01, {7'h00, a});
        bus_master_inst.wr_byte(lo, a);
        chk("addr lo ack", 8'h01, {7'h00, a});
    endtask

    // start and read-addressed slave byte
    task automatic rd_start();
        logic a;
        bus_master_inst.start_cond();
        bus_master_inst.wr_byte({DEV, SEL, 1'b1}, a);
        chk("read slave ack", 8'h01, {7'h00, a});
    endtask

    // four bytes across the top of the array, upper address bits set
    task automatic t_write_wrap();
        logic a;
        set_addr(8'hFF, 8'hFE);
        for (int i = 0; i < 4; i++) begin
            bus_master_inst.wr_byte(8'hA0 + 8'(i), a);
            chk("data ack", 8'h01, {7'h00, a});
        end
        bus_master_inst.stop_cond();
        $display("done write wrap");
    endtask

    // selective read over the top, end by nack then start, then current read
    task automatic t_read_wrap();
        logic [7:0] d;
        set_addr(8'h1F, 8'hFE);
        rd_start();
        bus_master_inst.rd_byte(1'b1, d);
        chk("read 1FFE", 8'hA0, d);
        bus_master_inst.rd_byte(1'b0, d);
        chk("read 1FFF", 8'hA1, d);
        rd_start();
        bus_master_inst.rd_byte(1'b1, d);
        chk("read 0000", 8'hA2, d);
        bus_master_inst.rd_byte(1'b0, d);
        chk("read 0001", 8'hA3, d);
        bus_master_inst.stop_cond();
        $display("done read wrap");
    endtask

    // protected data byte refused, address and contents kept
    task automatic t_protect();
        logic       a;
        logic [7:0] d;
        write_protect = 1'b1;
        set_addr(8'h00, 8'h00);
        bus_master_inst.wr_byte(8'h55, a);
        chk("protected ack", 8'h00, {7'h00, a});
        bus_master_inst.stop_cond();
        write_protect = 1'b0;
        rd_start();
        bus_master_inst.rd_byte(1'b0, d);
        chk("after protect", 8'hA2, d);
        bus_master_inst.stop_cond();
        $display("done protect");
    endtask

    // start after four data bits aborts the byte
    task automatic t_abort();
        logic       s;
        logic [7:0] d;
        set_addr(8'h00, 8'h01);
        for (int i = 7; i >= 4; i--) bus_master_inst.bit_clk(i[0], s);
        rd_start();
        bus_master_inst.rd_byte(1'b0, d);
        chk("after abort", 8'hA3, d);
        bus_master_inst.stop_cond();
        $display("done abort");
    endtask

    // slave bytes that name another device are not answered
    task automatic t_mismatch();
        logic       a;
        logic [7:0] bad [3];
        bad = '{{DEV, SEL ^ 3'h1, 1'b0}, {DEV ^ 4'h1, SEL, 1'b0}, {DEV, SEL ^ 3'h4, 1'b1}};
        for (int i = 0; i < 3; i++) begin
            bus_master_inst.start_cond();
            bus_master_inst.wr_byte(bad[i], a);
            chk("foreign slave nack", 8'h00, {7'h00, a});
            bus_master_inst.stop_cond();
        end
        $display("done mismatch");
    endtask

    // clock generator
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // cycle ceiling against a hang
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            $display("Error timeout expected finish seen hang");
            results();
        end
    end

    // reset, then scenarios in order
    initial begin
        err_total = 0;
        checked = 0;
        cycles = 0;
        nrst = 1'b0;
        write_protect = 1'b0;
        repeat (3) @(posedge clk);
        #2;
        nrst = 1'b1;
        bus_master_inst.wait_clk(2);
        t_write_wrap();
        t_read_wrap();
        t_protect();
        t_abort();
        t_mismatch();
        results();
    end
endmodule
